// ### rtl/spp_pkg.sv
package spp_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_CTLW = 5'h00;
  localparam logic [4:0] IDX_CTL0 = 5'h01;
  localparam logic [4:0] IDX_BRW = 5'h06;
  localparam logic [4:0] IDX_BR1 = 5'h07;
  localparam logic [4:0] IDX_MCTL = 5'h08;
  localparam logic [4:0] IDX_STAT = 5'h0a;
  localparam logic [4:0] IDX_RSV0B = 5'h0b;
  localparam logic [4:0] IDX_RXBUF = 5'h0c;
  localparam logic [4:0] IDX_RSV0D = 5'h0d;
  localparam logic [4:0] IDX_TXBUF = 5'h0e;
  localparam logic [4:0] IDX_RSV0F = 5'h0f;
  localparam logic [4:0] IDX_ICTL = 5'h1c;
  localparam logic [4:0] IDX_IFG = 5'h1d;
  localparam logic [4:0] IDX_IV = 5'h1e;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int CTL0_CPHA = 7;
  localparam int CTL0_CPOL = 6;
  localparam int CTL0_MSB = 5;
  localparam int CTL0_C7 = 4;
  localparam int CTL0_MST = 3;
  localparam int CTL0_MODE = 1;
  localparam int CTL1_SSEL = 6;
  localparam int CTL1_SWRST = 0;
  localparam int FLAG_TX = 1;
  localparam int FLAG_RX = 0;
  localparam logic [7:0] CTL1_MASK = 8'hc1;

  // ----------------------------------------------------------------
  // Reset values and codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL0_RST = 8'h01;
  localparam logic [7:0] CTL1_RST = 8'h01;
  localparam logic [1:0] IFG_RST = 2'h2;
  localparam logic [1:0] MODE_3PIN = 2'h0;
  localparam logic [1:0] MODE_4PIN_HI = 2'h1;
  localparam logic [1:0] MODE_4PIN_LO = 2'h2;
  localparam logic [1:0] MODE_I2C = 2'h3;
  localparam logic [1:0] SSEL_AUX = 2'h1;
  localparam logic [15:0] IV_NONE = 16'h0000;
  localparam logic [15:0] IV_RX = 16'h0002;
  localparam logic [15:0] IV_TX = 16'h0004;
  localparam logic [3:0] CHAR8 = 4'h8;
  localparam logic [3:0] CHAR7 = 4'h7;

  typedef enum logic {SPP_IDLE, SPP_SHIFT} spp_phase_type;

  typedef struct packed {
    logic aux_clock;
    logic main_clock;
    logic sclk;
    logic ste;
    logic sdi;
  } spp_pins_in_type;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic sdo;
    logic sdo_oe;
  } spp_pins_out_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } spp_div_type;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [15:0] br;
    logic [7:0] mctl;
    logic listen;
    logic fe;
    logic ovr;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic [1:0] ie;
    logic [1:0] ifg;
    logic tx_pending;
    spp_phase_type phase;
    logic [3:0] edge_cnt;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [2:0] prev;
    logic waitreq;
    logic [31:0] rdata;
    spp_pins_out_type pins;
  } spp_state_type;

endpackage

// ### rtl/spp_sync2.sv
`timescale 1ns/10ps
module spp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import spp_pkg::*;

  logic [W-1:0] meta;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // spp_sync2

// ### rtl/spp_bitclk_div.sv
`timescale 1ns/10ps
module spp_bitclk_div (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [15:0] divisor,
  output logic tick
);
  import spp_pkg::*;

  spp_div_type r;
  spp_div_type n;
  logic [15:0] last;

  // A divisor of zero behaves as one, the fastest rate available.
  always_comb begin
    n = r;
    last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 16'h0000;
    end else if (src_tick) begin
      if (r.cnt >= last) begin
        n.cnt = 16'h0000;
        n.tick = 1'b1;
      end else begin
        n.cnt = r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;
endmodule // spp_bitclk_div

// ### rtl/spp_port_bank.sv
`timescale 1ns/10ps
module spp_port_bank (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire spp_pkg::spp_pins_in_type pins_in,
  output spp_pkg::spp_pins_out_type pins_out
);
  import spp_pkg::*;

  localparam spp_state_type STATE_RST = '{
    ctl0: CTL0_RST, ctl1: CTL1_RST, br: 16'h0000, mctl: 8'h00,
    listen: 1'b0, fe: 1'b0, ovr: 1'b0, rxbuf: 8'h00, txbuf: 8'h00,
    ie: 2'h0, ifg: IFG_RST, tx_pending: 1'b0, phase: SPP_IDLE,
    edge_cnt: 4'h0, txsh: 8'h00, rxsh: 8'h00, prev: 3'h0,
    waitreq: 1'b1, rdata: 32'h0000_0000, pins: 4'h0};

  spp_state_type r;
  spp_state_type n;
  spp_pins_in_type s_in;
  logic div_run;
  logic src_tick;
  logic div_tick;
  logic take;
  logic done_now;
  logic start_now;
  logic [15:0] iv;
  logic [31:0] rd;
  logic cpha;
  logic cpol;
  logic msb;
  logic mst;
  logic swrst;
  logic four;
  logic ste_en;
  logic spi_ok;
  logic m_inact;
  logic s_inact;
  logic busy;
  logic sdi_eff;
  logic edge_ev;
  logic [1:0] mode;
  logic [3:0] nbits;
  logic [3:0] cnt;
  logic [3:0] bitn;
  logic [3:0] oidx;

  function automatic logic [2:0] bpos(input logic [3:0] i, input logic [3:0] nb,
                                      input logic m);
    logic [3:0] p;
    p = m ? nb - 4'h1 - i : i;
    return p[2:0];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and bit-clock divider.
  // ----------------------------------------------------------------
  spp_sync2 #(.W(5)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(pins_in),
    .q(s_in)
  );

  spp_bitclk_div u_div (
    .clk(clk),
    .rstn(rstn),
    .run(div_run),
    .src_tick(src_tick),
    .divisor(r.br),
    .tick(div_tick)
  );

  // ----------------------------------------------------------------
  // Decoded configuration and read view.
  // ----------------------------------------------------------------
  always_comb begin
    cpha = r.ctl0[CTL0_CPHA];
    cpol = r.ctl0[CTL0_CPOL];
    msb = r.ctl0[CTL0_MSB];
    mst = r.ctl0[CTL0_MST];
    mode = r.ctl0[CTL0_MODE +: 2];
    swrst = r.ctl1[CTL1_SWRST];
    nbits = r.ctl0[CTL0_C7] ? CHAR7 : CHAR8;
    four = (mode == MODE_4PIN_HI) || (mode == MODE_4PIN_LO);
    ste_en = (mode == MODE_4PIN_HI) ? s_in.ste : !s_in.ste;
    spi_ok = (mode != MODE_I2C);
    // A master sees the select at its slave-enable level as a rival master.
    m_inact = mst && four && ste_en;
    s_inact = !mst && four && !ste_en;
    busy = (r.phase == SPP_SHIFT) || (mst && r.tx_pending);
    if (r.ifg[FLAG_RX] && r.ie[FLAG_RX]) begin
      iv = IV_RX;
    end else if (r.ifg[FLAG_TX] && r.ie[FLAG_TX]) begin
      iv = IV_TX;
    end else begin
      iv = IV_NONE;
    end
    rd = 32'h0000_0000;
    case (avs_address)
      IDX_CTLW: rd[15:0] = {r.ctl0, r.ctl1};
      IDX_CTL0: rd[7:0] = r.ctl0;
      IDX_BRW: rd[15:0] = r.br;
      IDX_BR1: rd[7:0] = r.br[15:8];
      IDX_MCTL: rd[7:0] = r.mctl;
      IDX_STAT: rd[7:0] = {r.listen, r.fe, r.ovr, 4'h0, busy};
      IDX_RXBUF: rd[7:0] = r.rxbuf;
      IDX_TXBUF: rd[7:0] = r.txbuf;
      IDX_ICTL: rd[15:0] = {6'h00, r.ifg, 6'h00, r.ie};
      IDX_IFG: rd[7:0] = {6'h00, r.ifg};
      IDX_IV: rd[15:0] = iv;
      default: rd = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic: bus first, then shift engine, so that a
  // hardware set in the same cycle overrides a software clear.
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    take = (avs_read || avs_write) && !r.waitreq;
    done_now = 1'b0;
    start_now = 1'b0;
    // Bus answer: data captured on the first edge, effects on the second.
    n.waitreq = 1'b1;
    if ((avs_read || avs_write) && r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = rd;
    end
    if (take && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        IDX_CTLW: n.ctl1 = avs_writedata[7:0] & CTL1_MASK;
        IDX_CTL0: n.ctl0 = avs_writedata[7:0];
        IDX_BRW: n.br[7:0] = avs_writedata[7:0];
        IDX_BR1: n.br[15:8] = avs_writedata[7:0];
        IDX_MCTL: n.mctl = avs_writedata[7:0];
        IDX_STAT: {n.listen, n.fe, n.ovr} = avs_writedata[7:5];
        IDX_TXBUF: begin
          n.txbuf = r.ctl0[CTL0_C7] ? {1'b0, avs_writedata[6:0]}
                                    : avs_writedata[7:0];
          n.ifg[FLAG_TX] = 1'b0;
          n.tx_pending = 1'b1;
        end
        IDX_ICTL: n.ie = avs_writedata[1:0];
        IDX_IFG: n.ifg = avs_writedata[1:0];
        default: ;
      endcase
    end
    if (take && avs_write && avs_byteenable[1]) begin
      case (avs_address)
        IDX_CTLW: n.ctl0 = avs_writedata[15:8];
        IDX_BRW: n.br[15:8] = avs_writedata[15:8];
        IDX_ICTL: n.ifg = avs_writedata[9:8];
        default: ;
      endcase
    end
    if (take && avs_read && avs_address == IDX_RXBUF) begin
      n.ifg[FLAG_RX] = 1'b0;
      n.ovr = 1'b0;
      n.fe = 1'b0;
    end
    if (take && avs_address == IDX_IV) begin
      if (iv == IV_RX) begin
        n.ifg[FLAG_RX] = 1'b0;
      end else if (iv == IV_TX) begin
        n.ifg[FLAG_TX] = 1'b0;
      end
    end

    // Bit-clock source: rising edges of the synchronised source pins.
    n.prev = {s_in.aux_clock, s_in.main_clock, s_in.sclk};
    if (r.ctl1[CTL1_SSEL +: 2] == SSEL_AUX) begin
      src_tick = s_in.aux_clock && !r.prev[2];
    end else if (r.ctl1[CTL1_SSEL + 1]) begin
      src_tick = s_in.main_clock && !r.prev[1];
    end else begin
      src_tick = 1'b0;
    end
    div_run = mst && (r.phase == SPP_SHIFT) && !swrst && !m_inact;

    // Shift engine.
    sdi_eff = r.listen ? r.pins.sdo : s_in.sdi;
    if (mst) begin
      edge_ev = (r.phase == SPP_SHIFT) && div_tick && !m_inact;
    end else begin
      edge_ev = (s_in.sclk ^ r.prev[0]) && !s_inact && spi_ok;
    end
    cnt = (r.phase == SPP_IDLE) ? 4'h0 : r.edge_cnt;
    bitn = {1'b0, cnt[3:1]};
    oidx = cpha ? bitn + 4'h1 : bitn;
    if (edge_ev && !swrst) begin
      if (mst) begin
        n.pins.sclk = !r.pins.sclk;
      end
      if (cnt[0] == cpha) begin
        if (oidx < nbits) begin
          n.pins.sdo = r.txsh[bpos(oidx, nbits, msb)];
        end
      end else begin
        n.rxsh[bpos(bitn, nbits, msb)] = sdi_eff;
      end
      if (cnt == {nbits[2:0] - 3'h1, 1'b1}) begin
        done_now = 1'b1;
        n.phase = SPP_IDLE;
        n.edge_cnt = 4'h0;
        if (n.ifg[FLAG_RX]) begin
          n.ovr = 1'b1;
        end
        n.rxbuf = n.rxsh;
        n.ifg[FLAG_RX] = 1'b1;
        n.rxsh = 8'h00;
      end else begin
        n.phase = SPP_SHIFT;
        n.edge_cnt = cnt + 4'h1;
      end
    end
    // Loading the shift register frees the buffer for the next character.
    if (r.phase == SPP_IDLE && r.tx_pending && !swrst && spi_ok && !edge_ev
        && !m_inact) begin
      start_now = 1'b1;
      n.txsh = r.txbuf;
      n.tx_pending = 1'b0;
      n.ifg[FLAG_TX] = 1'b1;
      n.rxsh = 8'h00;
      if (cpha) begin
        n.pins.sdo = r.txbuf[bpos(4'h0, nbits, msb)];
      end
      if (mst) begin
        n.phase = SPP_SHIFT;
        n.edge_cnt = 4'h0;
      end
    end
    if (mst && r.phase == SPP_IDLE && !start_now) begin
      n.pins.sclk = cpol;
    end
    if (m_inact) begin
      n.fe = 1'b1;
      n.phase = SPP_IDLE;
      n.edge_cnt = 4'h0;
    end
    n.pins.sclk_oe = mst && !m_inact && !swrst && spi_ok;
    n.pins.sdo_oe = !swrst && spi_ok && (mst ? !m_inact : !s_inact);
    // Soft reset keeps the configuration except the interrupt enables, which it clears, and stops all traffic.
    if (swrst) begin
      n.phase = SPP_IDLE;
      n.edge_cnt = 4'h0;
      n.tx_pending = 1'b0;
      n.ifg = IFG_RST;
      n.ie = 2'h0;
      n.pins.sclk = cpol;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign pins_out = r.pins;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_bus_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence seq_rx_read;
    take && avs_read && avs_address == IDX_RXBUF;
  endsequence

  chk_bus_answer: assert property (seq_bus_wait |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not after one wait cycle.");
  chk_soft_reset: assert property (
    swrst |=> r.phase == SPP_IDLE && r.ifg == IFG_RST && r.ie == 2'h0)
    else $error("Soft reset did not hold the engine.");
  chk_idle_level: assert property (
    mst && r.phase == SPP_IDLE && $stable(cpol) ##1 r.phase == SPP_IDLE
    |-> pins_out.sclk == $past(cpol))
    else $error("Serial clock not at idle level.");
  chk_tx_clear: assert property (
    take && avs_write && avs_byteenable[0] && avs_address == IDX_TXBUF && !r.tx_pending
    && r.phase == SPP_SHIFT && !swrst |=> !r.ifg[FLAG_TX] && r.tx_pending)
    else $error("Transmit buffer write did not clear the flag.");
  chk_rx_done: assert property (
    done_now |=> r.ifg[FLAG_RX] && r.rxbuf == $past(n.rxbuf))
    else $error("Received character not moved.");
  chk_overrun_set: assert property (
    done_now && r.ifg[FLAG_RX] && !take |=> r.ovr)
    else $error("Overrun not flagged.");
  chk_rx_read: assert property (
    seq_rx_read ##0 (!done_now && !swrst) |=> !r.ifg[FLAG_RX] && !r.ovr)
    else $error("Receive read did not clear flags.");
  chk_vector_clear: assert property (
    take && avs_address == IDX_IV && iv == IV_RX && !done_now |=> !r.ifg[FLAG_RX])
    else $error("Vector access did not clear receive flag.");
  chk_conflict_flag: assert property (
    m_inact && !(take && avs_write) |=> r.fe && !pins_out.sclk_oe)
    else $error("Bus conflict not flagged.");
  chk_master_start: assert property (
    mst && start_now |=> r.phase == SPP_SHIFT && r.ifg[FLAG_TX] ##1 busy)
    else $error("Master did not start after buffer write.");
  chk_rx_top_bit: assert property (
    done_now && r.ctl0[CTL0_C7] |=> !r.rxbuf[7])
    else $error("Top bit set in 7-bit receive.");
endmodule // spp_port_bank

// ### sim/spp_slave_model.sv
`timescale 1ns/10ps
module spp_slave_model (
  input wire logic sclk,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic msb,
  input wire logic c7,
  input wire logic arm,
  input wire logic [7:0] reply,
  input wire logic sdo,
  output logic sdi,
  output logic [7:0] got
);
  int cnt = 0;
  logic active = 1'b0;
  logic [7:0] tx = 8'h00;

  function automatic int nbits();
    return c7 ? 7 : 8;
  endfunction

  function automatic int pos(input int k);
    return msb ? nbits() - 1 - k : k;
  endfunction

  initial begin
    sdi = 1'b0;
    got = 8'h00;
  end

  // With phase 1 the first bit must already stand before the first edge.
  always @(posedge arm) begin
    tx = reply;
    cnt = 0;
    got = 8'h00;
    active = 1'b1;
    if (cpha) begin
      sdi = tx[pos(0)];
    end
  end

  always @(sclk) begin
    if (active) begin
      if ((sclk != cpol) != cpha) begin
        if (cnt < nbits()) begin
          sdi = tx[pos(cnt)];
        end
      end else begin
        got[pos(cnt)] = sdo;
        cnt++;
        // A released line must not keep its last value, or a late sample would pass.
        if (cnt == nbits()) begin
          active = 1'b0;
          sdi = ~sdi;
        end
      end
    end
  end
endmodule // spp_slave_model

// ### sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  import spp_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [7:0] CFG [6] = '{8'h09, 8'h49, 8'h89, 8'hf9, 8'h39, 8'h0d};
  localparam logic [1:0] SRC [6] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h2, 2'h3};
  localparam logic [4:0] RSV [4] = '{IDX_RSV0B, IDX_RSV0D, IDX_RSV0F, 5'h02};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic aux_clk = 1'b0;
  logic main_clk = 1'b0;
  logic ste = 1'b1;
  logic tb_sclk = 1'b0;
  logic arm = 1'b0;
  logic [7:0] reply = 8'h00;
  logic [7:0] cur = 8'h00;
  logic sdi;
  logic [7:0] got;
  spp_pins_in_type pins_in;
  spp_pins_out_type pins_out;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // The clock pin has a pull-down, so a released pin reads low.
  // In slave mode the bench plays the outside master on tb_sclk.
  assign pins_in = '{aux_clock: aux_clk, main_clock: main_clk,
                     sclk: (pins_out.sclk_oe & pins_out.sclk) | tb_sclk, ste: ste, sdi: sdi};

  spp_port_bank i_dut (
    .clk(clk),
    .rstn(rstn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pins_in(pins_in),
    .pins_out(pins_out)
  );

  spp_slave_model i_slave (
    .sclk(pins_out.sclk),
    .cpol(cur[CTL0_CPOL]),
    .cpha(cur[CTL0_CPHA]),
    .msb(cur[CTL0_MSB]),
    .c7(cur[CTL0_C7]),
    .arm(arm),
    .reply(reply),
    .sdo(pins_out.sdo),
    .sdi(sdi),
    .got(got)
  );

  always #12.5 clk = ~clk;
  always #50 main_clk = ~main_clk;
  always #100 aux_clk = ~aux_clk;

  // ------------------------------------------------------------
  // Reporting.
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("Totals: %0d checks, %0d mismatches", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] val, input logic [31:0] exp);
    checks_done++;
    if (val !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, val, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Register bus.
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    // Only the bench timeout ends a wait that never gets its answer.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'h3, q);
    chk(q & mask, exp);
  endtask

  task automatic poll(input logic [4:0] a, input int b, input logic v);
    logic [31:0] q;
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, a, 16'h0000, 4'h3, q);
      if (q[b] === v) begin
        break;
      end
    end
    chk({31'h0, q[b]}, {31'h0, v});
  endtask

  task automatic cfg(input logic [7:0] c0, input logic [1:0] src);
    cur = c0;
    wr(IDX_CTLW, {c0, src, 6'h01}, 4'h3);
    wr(IDX_MCTL, 16'h0000, 4'h1);
    wr(IDX_CTLW, {c0, src, 6'h00}, 4'h3);
  endtask

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(IDX_CTLW, 32'hffff, 32'h0101);
    rd(IDX_ICTL, 32'hffff, 32'h0200);
    rd(IDX_IV, 32'hffff, 32'h0000);
    wr(IDX_BRW, 16'h1234, 4'h3);
    rd(IDX_BR1, 32'hff, 32'h12);
    rd(IDX_BRW, 32'hffff, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      wr(RSV[i], 16'hffff, 4'h3);
      rd(RSV[i], 32'hffffffff, 32'h0);
    end
    wr(IDX_BRW, 16'h0002, 4'h3);
    $display("Test registers done");
  endtask

  task automatic t_xfer(input logic [7:0] c0, input logic [1:0] src, input logic [7:0] tx,
                        input logic [7:0] rx);
    logic [7:0] m;
    m = c0[CTL0_C7] ? 8'h7f : 8'hff;
    cfg(c0, src);
    repeat (4) @(posedge clk);
    chk({31'h0, pins_out.sclk}, {31'h0, c0[CTL0_CPOL]});
    chk({30'h0, pins_out.sclk_oe, pins_out.sdo_oe}, 32'h3);
    reply <= rx;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    wr(IDX_TXBUF, {8'h00, tx}, 4'h1);
    rd(IDX_STAT, 32'h41, 32'h01);
    poll(IDX_IFG, FLAG_RX, 1'b1);
    rd(IDX_RXBUF, 32'hff, {24'h0, rx & m});
    chk({24'h0, got}, {24'h0, tx & m});
    rd(IDX_IFG, 32'h1, 32'h0);
    $display("Test transfer cfg %h done", c0);
  endtask

  task automatic t_overrun();
    cfg(8'h29, 2'h2);
    wr(IDX_STAT, 16'h0080, 4'h1);
    wr(IDX_TXBUF, 16'h00a1, 4'h1);
    wr(IDX_TXBUF, 16'h005e, 4'h1);
    rd(IDX_IFG, 32'h2, 32'h0);
    poll(IDX_STAT, 0, 1'b0);
    rd(IDX_STAT, 32'h20, 32'h20);
    rd(IDX_RXBUF, 32'hff, 32'h5e);
    rd(IDX_STAT, 32'h20, 32'h0);
    $display("Test overrun done");
  endtask

  task automatic t_vector();
    wr(IDX_ICTL, 16'h00ff, 4'h1);
    rd(IDX_ICTL, 32'hffff, 32'h0203);
    wr(IDX_TXBUF, 16'h005a, 4'h1);
    poll(IDX_IFG, FLAG_RX, 1'b1);
    rd(IDX_IV, 32'hffff, 32'h0002);
    rd(IDX_IV, 32'hffff, 32'h0004);
    rd(IDX_IV, 32'hffff, 32'h0000);
    rd(IDX_IFG, 32'hff, 32'h00);
    rd(IDX_RXBUF, 32'hff, 32'h5a);
    $display("Test vector done");
  endtask

  task automatic t_conflict();
    cfg(8'h0b, 2'h2);
    wr(IDX_TXBUF, 16'h0033, 4'h1);
    repeat (8) @(posedge clk);
    rd(IDX_STAT, 32'h40, 32'h40);
    chk({31'h0, pins_out.sclk_oe}, 32'h0);
    chk({31'h0, pins_out.sdo_oe}, 32'h0);
    ste <= 1'b0;
    poll(IDX_STAT, 0, 1'b0);
    rd(IDX_RXBUF, 32'hff, 32'h33);
    rd(IDX_STAT, 32'h40, 32'h0);
    $display("Test conflict done");
  endtask

  task automatic t_slave();
    cfg(8'h01, 2'h0);
    wr(IDX_STAT, 16'h0080, 4'h1);
    wr(IDX_TXBUF, 16'h00c5, 4'h1);
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(posedge clk);
      tb_sclk <= ~tb_sclk;
      if (i == 8) begin
        rd(IDX_STAT, 32'h1, 32'h1);
      end
    end
    repeat (6) @(posedge clk);
    rd(IDX_RXBUF, 32'hff, 32'hc5);
    rd(IDX_STAT, 32'h1, 32'h0);
    $display("Test slave done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    for (int i = 0; i < 6; i++) begin
      t_xfer(CFG[i], SRC[i], 8'h96 ^ 8'(i * 17), 8'hc3 + 8'(i));
    end
    t_overrun();
    t_vector();
    t_conflict();
    t_slave();
    print_verdict();
  end
endmodule // testbench
